// >>> pkg/srp_pkg.sv
// Package for the serial receiver PHY and PLL control register bank.
// Assumes an 8-bit register port with 10-bit addresses on core_clk.
package srp_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [9:0] SRP_ADDR_MASTER_PD = 10'h200;
  localparam logic [9:0] SRP_ADDR_LANE_PD = 10'h201;
  localparam logic [9:0] SRP_ADDR_MISC_PD = 10'h203;
  localparam logic [9:0] SRP_ADDR_RECOV_RST = 10'h206;
  localparam logic [9:0] SRP_ADDR_RECOV_MODE = 10'h230;
  localparam logic [9:0] SRP_ADDR_EQ_BIAS = 10'h268;
  localparam logic [9:0] SRP_ADDR_PLL_CTRL = 10'h280;
  localparam logic [9:0] SRP_ADDR_PLL_STATUS = 10'h281;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SRP_BIT_MASTER_PD = 0;
  localparam int SRP_BIT_SYNC_PD = 1;
  localparam int SRP_BIT_RECOV_RST_N = 0;
  localparam int SRP_BIT_HALF_RATE = 5;
  localparam int SRP_BIT_OVERSAMP = 1;
  localparam int SRP_BIT_SWING = 0;
  localparam int SRP_BIT_PLL_EN = 0;
  localparam int SRP_BIT_PLL_RECAL = 2;
  localparam int SRP_BIT_LOCKED = 0;
  localparam int SRP_BIT_CAL_DONE = 3;
  localparam int SRP_BIT_OVR_HIGH = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SRP_RST_MASTER_PD = 8'h01;
  localparam logic [7:0] SRP_RST_LANE_PD = 8'h00;
  localparam logic [7:0] SRP_RST_MISC_PD = 8'h00;
  localparam logic [7:0] SRP_RST_RECOV_RST = 8'h01;
  localparam logic [7:0] SRP_RST_RECOV_MODE = 8'h28;
  localparam logic [7:0] SRP_RST_EQ_BIAS = 8'h62;
  localparam logic [7:0] SRP_RST_PLL_CTRL = 8'h00;

  // Equalizer power codes
  localparam logic [1:0] SRP_EQ_NORMAL = 2'h0;
  localparam logic [1:0] SRP_EQ_LOW_POWER = 2'h1;

  typedef struct packed {
    logic [7:0] master_pd;
    logic [7:0] lane_pd;
    logic [7:0] misc_pd;
    logic [7:0] recov_rst;
    logic [7:0] recov_mode;
    logic [7:0] eq_bias;
    logic [7:0] pll_ctrl;
    logic [7:0] rd_data;
    logic cal_start;
    logic [1:0] locked_sync;
    logic [1:0] cal_done_sync;
    logic [1:0] ovr_sync;
  } srp_state_t;

endpackage

// >>> src/srp_regs.sv
// Serial receiver PHY and PLL control register bank.
// Assumes the serial configuration port is decoded to write/read strobes on core_clk,
// and PLL status levels arrive from the analog side asynchronously.
// Reserved bits are stored and read back as written;
// unmapped reads return zero and unmapped writes vanish.
module srp_regs
  import srp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [9:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic pll_locked_in,
  input wire logic pll_cal_done_in,
  input wire logic pll_overrange_in,
  output logic receiver_master_powerdown,
  output logic [3:0] lane_phy_powerdown_bits,
  output logic sync_buffer_powerdown,
  output logic recovery_reset_n,
  output logic half_rate_recovery_en,
  output logic input_oversample_en,
  output logic sync_out_swing_sel,
  output logic [1:0] equalizer_power_sel,
  output logic serial_pll_en,
  output logic serial_pll_cal_start
);

  srp_state_t st;
  srp_state_t next_st;
  logic [7:0] status_word;
  logic wr_master;
  logic wr_lane;
  logic wr_misc;
  logic wr_recov_rst;
  logic wr_recov_mode;
  logic wr_eq_bias;
  logic wr_pll_ctrl;
  logic recal_rise;
  logic enable_rise;
  logic [7:0] rd_word;

  // ****************************************
  // Status word
  // ****************************************
  always_comb begin
    status_word = 8'h00;
    status_word[SRP_BIT_LOCKED] = st.locked_sync[1];
    status_word[SRP_BIT_CAL_DONE] = st.cal_done_sync[1];
    status_word[SRP_BIT_OVR_HIGH] = st.ovr_sync[1];
  end

  // ****************************************
  // Write decode
  // ****************************************
  always_comb begin
    wr_master = 1'b0;
    wr_lane = 1'b0;
    wr_misc = 1'b0;
    wr_recov_rst = 1'b0;
    wr_recov_mode = 1'b0;
    wr_eq_bias = 1'b0;
    wr_pll_ctrl = 1'b0;
    if (cfg_wr) begin
      case (cfg_addr)
        SRP_ADDR_MASTER_PD: wr_master = 1'b1;
        SRP_ADDR_LANE_PD: wr_lane = 1'b1;
        SRP_ADDR_MISC_PD: wr_misc = 1'b1;
        SRP_ADDR_RECOV_RST: wr_recov_rst = 1'b1;
        SRP_ADDR_RECOV_MODE: wr_recov_mode = 1'b1;
        SRP_ADDR_EQ_BIAS: wr_eq_bias = 1'b1;
        SRP_ADDR_PLL_CTRL: wr_pll_ctrl = 1'b1;
        SRP_ADDR_PLL_STATUS: ;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Edge detect
  // ****************************************
  // compare with stored
  assign recal_rise = cfg_wdata[SRP_BIT_PLL_RECAL] & ~st.pll_ctrl[SRP_BIT_PLL_RECAL];
  assign enable_rise = cfg_wdata[SRP_BIT_PLL_EN] & ~st.pll_ctrl[SRP_BIT_PLL_EN];

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    case (cfg_addr)
      SRP_ADDR_MASTER_PD: rd_word = st.master_pd;
      SRP_ADDR_LANE_PD: rd_word = st.lane_pd;
      SRP_ADDR_MISC_PD: rd_word = st.misc_pd;
      SRP_ADDR_RECOV_RST: rd_word = st.recov_rst;
      SRP_ADDR_RECOV_MODE: rd_word = st.recov_mode;
      SRP_ADDR_EQ_BIAS: rd_word = st.eq_bias;
      SRP_ADDR_PLL_CTRL: rd_word = st.pll_ctrl;
      SRP_ADDR_PLL_STATUS: rd_word = status_word;
      default: rd_word = 8'h00;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.cal_start = 1'b0;
    // Two flops per status level
    next_st.locked_sync = {st.locked_sync[0], pll_locked_in};
    next_st.cal_done_sync = {st.cal_done_sync[0], pll_cal_done_in};
    next_st.ovr_sync = {st.ovr_sync[0], pll_overrange_in};
    // Register writes
    if (wr_master) begin
      next_st.master_pd = cfg_wdata;
    end
    if (wr_lane) begin
      next_st.lane_pd = cfg_wdata;
    end
    if (wr_misc) begin
      next_st.misc_pd = cfg_wdata;
    end
    if (wr_recov_rst) begin
      next_st.recov_rst = cfg_wdata;
    end
    if (wr_recov_mode) begin
      next_st.recov_mode = cfg_wdata;
    end
    if (wr_eq_bias) begin
      next_st.eq_bias = cfg_wdata;
    end
    if (wr_pll_ctrl) begin
      next_st.pll_ctrl = cfg_wdata;
      // One pulse when enable or recal rises, even if both rise in the same write
      next_st.cal_start = recal_rise | enable_rise;
    end
    // Read capture, held between reads
    if (cfg_rd) begin
      next_st.rd_data = rd_word;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st.master_pd <= SRP_RST_MASTER_PD;
      st.lane_pd <= SRP_RST_LANE_PD;
      st.misc_pd <= SRP_RST_MISC_PD;
      st.recov_rst <= SRP_RST_RECOV_RST;
      st.recov_mode <= SRP_RST_RECOV_MODE;
      st.eq_bias <= SRP_RST_EQ_BIAS;
      st.pll_ctrl <= SRP_RST_PLL_CTRL;
      st.rd_data <= 8'h00;
      st.cal_start <= 1'b0;
      st.locked_sync <= 2'h0;
      st.cal_done_sync <= 2'h0;
      st.ovr_sync <= 2'h0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cfg_rdata = st.rd_data;
  assign receiver_master_powerdown = st.master_pd[SRP_BIT_MASTER_PD];
  assign lane_phy_powerdown_bits = st.lane_pd[3:0];
  assign sync_buffer_powerdown = st.misc_pd[SRP_BIT_SYNC_PD];
  assign recovery_reset_n = st.recov_rst[SRP_BIT_RECOV_RST_N];

  // ****************************************
  // Lane mode and swing
  // ****************************************
  assign half_rate_recovery_en = st.recov_mode[SRP_BIT_HALF_RATE];
  assign input_oversample_en = st.recov_mode[SRP_BIT_OVERSAMP];
  assign sync_out_swing_sel = st.recov_mode[SRP_BIT_SWING];
  assign equalizer_power_sel = st.eq_bias[7:6];

  // ****************************************
  // PLL control
  // ****************************************
  // PLL enable level
  assign serial_pll_en = st.pll_ctrl[SRP_BIT_PLL_EN];
  assign serial_pll_cal_start = st.cal_start;

endmodule

// >>> bench/srp_regs_props.sv
// Checker for the register bank, bound to every srp_regs.
// Assumes one clock domain and a synchronous reset.
module srp_regs_props
  import srp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [9:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic pll_locked_in,
  input wire logic pll_cal_done_in,
  input wire logic pll_overrange_in,
  input wire logic receiver_master_powerdown,
  input wire logic [3:0] lane_phy_powerdown_bits,
  input wire logic sync_buffer_powerdown,
  input wire logic recovery_reset_n,
  input wire logic half_rate_recovery_en,
  input wire logic input_oversample_en,
  input wire logic sync_out_swing_sel,
  input wire logic [1:0] equalizer_power_sel,
  input wire logic serial_pll_en,
  input wire logic serial_pll_cal_start
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [9:0] wa;
  logic [7:0] pw;
  logic [7:0] pc;
  wire [2:0] stat_in = {pll_overrange_in, pll_cal_done_in, pll_locked_in};
  // Write address, or an unmapped one when idle
  assign wa = cfg_wr ? cfg_addr : 10'h3ff;
  always_ff @(posedge core_clk) pw <= cfg_wdata;
  // Shadow of the stored PLL control word
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc <= SRP_RST_PLL_CTRL;
    end else if (wa == SRP_ADDR_PLL_CTRL) begin
      pc <= cfg_wdata;
    end
  end
  property p_lane; wa == SRP_ADDR_LANE_PD |=> lane_phy_powerdown_bits == pw[3:0]; endproperty
  a_lane: assert property (p_lane) else $error("lane pd");
  property p_sync; wa == SRP_ADDR_MISC_PD |=> sync_buffer_powerdown == pw[1]; endproperty
  a_sync: assert property (p_sync) else $error("sync pd");
  property p_rrst; wa == SRP_ADDR_RECOV_RST |=> recovery_reset_n == pw[0]; endproperty
  a_rrst: assert property (p_rrst) else $error("recov rst");
  property p_swing; wa == SRP_ADDR_RECOV_MODE |=> sync_out_swing_sel == pw[0]; endproperty
  a_swing: assert property (p_swing) else $error("swing");
  property p_eq; wa == SRP_ADDR_EQ_BIAS |=> equalizer_power_sel == pw[7:6]; endproperty
  a_eq: assert property (p_eq) else $error("eq sel");
  property p_en; wa == SRP_ADDR_PLL_CTRL && cfg_wdata[0] && !serial_pll_en |=> serial_pll_en && serial_pll_cal_start;
  endproperty
  a_en: assert property (p_en) else $error("pll en");
  property p_cal; serial_pll_cal_start |-> $past(wa) == SRP_ADDR_PLL_CTRL; endproperty
  a_cal: assert property (p_cal) else $error("cal start");
  property p_stat; $stable(stat_in)[*3] ##0 cfg_rd && cfg_addr == SRP_ADDR_PLL_STATUS
    |=> {cfg_rdata[5], cfg_rdata[3], cfg_rdata[0]} == $past(stat_in); endproperty
  a_stat: assert property (p_stat) else $error("status");
  property p_master; wa == SRP_ADDR_MASTER_PD |=> receiver_master_powerdown == pw[0]; endproperty
  a_master: assert property (p_master) else $error("master pd");
  property p_mode; wa == SRP_ADDR_RECOV_MODE |=> {half_rate_recovery_en, input_oversample_en} == {pw[5], pw[1]};
  endproperty
  a_mode: assert property (p_mode) else $error("rate mode");
  property p_edge; wa == SRP_ADDR_PLL_CTRL |=> serial_pll_cal_start ==
    ((pw[2] & ~$past(pc[2])) | (pw[0] & ~$past(pc[0]))); endproperty
  a_edge: assert property (p_edge) else $error("cal edge");
endmodule
bind srp_regs srp_regs_props u_props (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .cfg_wr(cfg_wr),
  .cfg_rd(cfg_rd),
  .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata),
  .pll_locked_in(pll_locked_in),
  .pll_cal_done_in(pll_cal_done_in),
  .pll_overrange_in(pll_overrange_in),
  .receiver_master_powerdown(receiver_master_powerdown),
  .lane_phy_powerdown_bits(lane_phy_powerdown_bits),
  .sync_buffer_powerdown(sync_buffer_powerdown),
  .recovery_reset_n(recovery_reset_n),
  .half_rate_recovery_en(half_rate_recovery_en),
  .input_oversample_en(input_oversample_en),
  .sync_out_swing_sel(sync_out_swing_sel),
  .equalizer_power_sel(equalizer_power_sel),
  .serial_pll_en(serial_pll_en),
  .serial_pll_cal_start(serial_pll_cal_start)
);

// >>> bench/srp_regs_tb_top.sv
// Testbench for the register bank; drives every port directly.
// Assumes one-cycle register latency on core_clk.
module srp_regs_tb_top
  import srp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, sys_rst = 1, cfg_wr = 0, cfg_rd = 0, lk = 0, cd = 0, ov = 0;
  logic [9:0] cfg_addr = 10'h0;
  logic [7:0] cfg_wdata = 8'h0, cfg_rdata, d;
  logic mpd, spd, rrn, hr, os, sw, pen, cs;
  logic [3:0] lpd;
  logic [1:0] eq;
  int num_errors = 0, n_tests = 0;
  logic [9:0] ra [7] = '{10'h200, 10'h201, 10'h203, 10'h206, 10'h230, 10'h268, 10'h280};
  logic [15:0] rv [7] = '{16'h01, 16'h00, 16'h00, 16'h01, 16'h28, 16'h62, 16'h00};
  wire [15:0] outs = {2'h0, mpd, lpd, spd, rrn, hr, os, sw, eq, pen, cs};
  srp_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pll_locked_in(lk), .pll_cal_done_in(cd), .pll_overrange_in(ov),
    .receiver_master_powerdown(mpd), .lane_phy_powerdown_bits(lpd), .sync_buffer_powerdown(spd),
    .recovery_reset_n(rrn), .half_rate_recovery_en(hr), .input_oversample_en(os), .sync_out_swing_sel(sw),
    .equalizer_power_sel(eq), .serial_pll_en(pen), .serial_pll_cal_start(cs));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One access; read data lands in d
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1 cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_wdata = v;
    @(posedge core_clk);
    #1 cfg_wr = 0;
    cfg_rd = 0;
    d = cfg_rdata;
  endtask
  task automatic t_reset;
    chk(outs, 16'h20c4);
    for (int i = 0; i < 7; i++) begin
      acc(0, ra[i], 8'h0);
      chk({8'h0, d}, rv[i]);
    end
  endtask
  task automatic t_ctrl;
    acc(1, 10'h201, 8'h35);
    acc(1, 10'h203, 8'h02);
    acc(1, 10'h206, 8'h00);
    acc(1, 10'h230, 8'h0b);
    acc(1, 10'h268, 8'h22);
    acc(1, 10'h200, 8'h00);
    chk(outs, 16'h0b30);
    acc(0, 10'h201, 8'h0);
    chk({8'h0, d}, 16'h35);
  endtask
  task automatic t_pll;
    acc(1, 10'h280, 8'h01);
    chk({14'h0, pen, cs}, 16'h3);
    acc(1, 10'h280, 8'h01);
    chk({14'h0, pen, cs}, 16'h2);
    acc(1, 10'h280, 8'h05);
    chk({14'h0, pen, cs}, 16'h3);
    acc(1, 10'h280, 8'h05);
    chk({14'h0, pen, cs}, 16'h2);
  endtask
  task automatic t_stat;
    lk = 1;
    cd = 1;
    ov = 1;
    repeat (3) @(posedge core_clk);
    acc(0, 10'h281, 8'h0);
    chk({8'h0, d}, 16'h29);
    acc(1, 10'h281, 8'hff);
    acc(0, 10'h281, 8'h0);
    chk({8'h0, d}, 16'h29);
    acc(0, 10'h3ff, 8'h0);
    chk({8'h0, d}, 16'h0);
    chk(outs, 16'h0b32);
    lk = 0;
    cd = 0;
    ov = 0;
    repeat (3) @(posedge core_clk);
    acc(0, 10'h281, 8'h0);
    chk({8'h0, d}, 16'h0);
  endtask
  // Reset in mid-run restores defaults
  task automatic t_rerst;
    @(posedge core_clk);
    #1 sys_rst = 1;
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 0;
    chk(outs, 16'h20c4);
    chk({8'h0, cfg_rdata}, 16'h0);
    acc(0, 10'h280, 8'h0);
    chk({8'h0, d}, 16'h0);
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1 sys_rst = 0;
    t_reset;
    t_ctrl;
    t_pll;
    t_stat;
    t_rerst;
    test_done;
  end
endmodule
